/* jtap_pkg.sv */
// Shared constants and types of the test access port: path lengths, instruction codes,
// controller states and reset values.
// Assumes nothing of its surroundings; every design file names its items as jtap_pkg::name.
package jtap_pkg;

	// Lengths of the serial paths between the data input and the data output.
	localparam int IR_LEN  = 3;
	localparam int BYP_LEN = 1;
	localparam int ID_LEN  = 32;
	localparam int BSR_LEN = 107;

	// Position of the internal boundary cell that steers the memory output bus.
	localparam int OE_CELL = 47;

	// Instruction codes; the three codes not listed here are reserved.
	localparam logic [2:0] INS_EXTEST  = 3'h0;
	localparam logic [2:0] INS_IDCODE  = 3'h1;
	localparam logic [2:0] INS_SAMPLEZ = 3'h2;
	localparam logic [2:0] INS_SAMPLE  = 3'h4;
	localparam logic [2:0] INS_BYPASS  = 3'h7;

	// Fixed pattern placed in the two low instruction bits on capture.
	localparam logic [1:0] IR_CAPTURE_LOW = 2'h1;

	// Value of the boundary update latches after reset: only the output-enable cell is high.
	localparam logic [BSR_LEN-1:0] BSR_UPD_RESET = 107'h8000_0000_0000;

	// Value loaded into the bypass cell on capture.
	localparam logic BYP_CAPTURE = 1'h0;

	// Controller states, Gray coded along the data path and then the instruction path.
	typedef enum logic [3:0] {
		ST_RESET   = 4'h0,
		ST_IDLE    = 4'h1,
		ST_SEL_DR  = 4'h3,
		ST_CAP_DR  = 4'h2,
		ST_SH_DR   = 4'h6,
		ST_EX1_DR  = 4'h7,
		ST_PS_DR   = 4'h5,
		ST_EX2_DR  = 4'h4,
		ST_UPD_DR  = 4'hc,
		ST_SEL_IR  = 4'hd,
		ST_CAP_IR  = 4'hf,
		ST_SH_IR   = 4'he,
		ST_EX1_IR  = 4'ha,
		ST_PS_IR   = 4'hb,
		ST_EX2_IR  = 4'h9,
		ST_UPD_IR  = 4'h8
	} jtap_state_t;

	// Which data register sits between the serial input and output.
	typedef enum logic [1:0] {
		PATH_BYP = 2'h0,
		PATH_ID  = 2'h1,
		PATH_BSR = 2'h2
	} jtap_path_t;

endpackage

/* jtap_step_if.sv */
// Interface carrying the decoded controller steps from the state machine to the core.
// Assumes both ends run on the test clock.
`timescale 1ns/1ns
`default_nettype none

interface jtap_step_if;
	logic tlr;       // Controller sits in the reset state.
	logic captureIr; // Instruction capture step.
	logic shiftIr;   // Instruction shift step.
	logic updateIr;  // Instruction update step.
	logic captureDr; // Data capture step.
	logic shiftDr;   // Data shift step.
	logic updateDr;  // Data update step.

	// The state machine drives the steps.
	modport ctl (output tlr, captureIr, shiftIr, updateIr, captureDr, shiftDr, updateDr);
	// The core only reads them.
	modport core (input tlr, captureIr, shiftIr, updateIr, captureDr, shiftDr, updateDr);
endinterface

`default_nettype wire

/* jtap_sync.sv */
// Two-flop synchroniser for a bus of independent levels.
// Assumes each bit may be sampled alone; words needing coherence use a toggle beside it.
`timescale 1ns/1ns
`default_nettype none

module jtap_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_ff; // First stage; read only by the second stage.
	logic [W-1:0] sync_ff; // Second stage, safe to use.

	// No reset here: this stage also brings the reset itself across.
	always_ff @(posedge clk) begin
		meta_ff <= d;
		sync_ff <= meta_ff;
	end

	assign q = sync_ff;

endmodule

`default_nettype wire

/* jtap_fsm.sv */
// Sixteen-state test controller stepped by the mode select on each rising test clock.
// Assumes its reset is already synchronous to the test clock.
`timescale 1ns/1ns
`default_nettype none

module jtap_fsm (
	input  wire logic tck,
	input  wire logic tckRst,
	input  wire logic tms,
	jtap_step_if.ctl  step
);

	jtap_pkg::jtap_state_t state_ff;  // Present controller state.
	jtap_pkg::jtap_state_t nxt_state; // State for the next rising edge.

	// Transition table; every arc is chosen by the mode-select level alone.
	always_comb begin
		case (state_ff)
			jtap_pkg::ST_RESET:  nxt_state = tms ? jtap_pkg::ST_RESET  : jtap_pkg::ST_IDLE;
			jtap_pkg::ST_IDLE:   nxt_state = tms ? jtap_pkg::ST_SEL_DR : jtap_pkg::ST_IDLE;
			jtap_pkg::ST_SEL_DR: nxt_state = tms ? jtap_pkg::ST_SEL_IR : jtap_pkg::ST_CAP_DR;
			jtap_pkg::ST_CAP_DR: nxt_state = tms ? jtap_pkg::ST_EX1_DR : jtap_pkg::ST_SH_DR;
			jtap_pkg::ST_SH_DR:  nxt_state = tms ? jtap_pkg::ST_EX1_DR : jtap_pkg::ST_SH_DR;
			jtap_pkg::ST_EX1_DR: nxt_state = tms ? jtap_pkg::ST_UPD_DR : jtap_pkg::ST_PS_DR;
			jtap_pkg::ST_PS_DR:  nxt_state = tms ? jtap_pkg::ST_EX2_DR : jtap_pkg::ST_PS_DR;
			jtap_pkg::ST_EX2_DR: nxt_state = tms ? jtap_pkg::ST_UPD_DR : jtap_pkg::ST_SH_DR;
			jtap_pkg::ST_UPD_DR: nxt_state = tms ? jtap_pkg::ST_SEL_DR : jtap_pkg::ST_IDLE;
			jtap_pkg::ST_SEL_IR: nxt_state = tms ? jtap_pkg::ST_RESET  : jtap_pkg::ST_CAP_IR;
			jtap_pkg::ST_CAP_IR: nxt_state = tms ? jtap_pkg::ST_EX1_IR : jtap_pkg::ST_SH_IR;
			jtap_pkg::ST_SH_IR:  nxt_state = tms ? jtap_pkg::ST_EX1_IR : jtap_pkg::ST_SH_IR;
			jtap_pkg::ST_EX1_IR: nxt_state = tms ? jtap_pkg::ST_UPD_IR : jtap_pkg::ST_PS_IR;
			jtap_pkg::ST_PS_IR:  nxt_state = tms ? jtap_pkg::ST_EX2_IR : jtap_pkg::ST_PS_IR;
			jtap_pkg::ST_EX2_IR: nxt_state = tms ? jtap_pkg::ST_UPD_IR : jtap_pkg::ST_SH_IR;
			jtap_pkg::ST_UPD_IR: nxt_state = tms ? jtap_pkg::ST_SEL_DR : jtap_pkg::ST_IDLE;
			default:             nxt_state = jtap_pkg::ST_RESET;
		endcase
	end

	// State register; power-up reset lands in the reset state like five high selects would.
	always_ff @(posedge tck) begin
		if (tckRst) begin
			state_ff <= jtap_pkg::ST_RESET;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Step decodes for the core.
	assign step.tlr       = (state_ff == jtap_pkg::ST_RESET);
	assign step.captureIr = (state_ff == jtap_pkg::ST_CAP_IR);
	assign step.shiftIr   = (state_ff == jtap_pkg::ST_SH_IR);
	assign step.updateIr  = (state_ff == jtap_pkg::ST_UPD_IR);
	assign step.captureDr = (state_ff == jtap_pkg::ST_CAP_DR);
	assign step.shiftDr   = (state_ff == jtap_pkg::ST_SH_DR);
	assign step.updateDr  = (state_ff == jtap_pkg::ST_UPD_DR);

	// Five high selects reach the reset state from anywhere.
	sequence selHighFive;
		tms [*5];
	endsequence

	a_five_ones_reset: assert property (@(posedge tck) disable iff (tckRst)
		selHighFive |=> (state_ff == jtap_pkg::ST_RESET))
		else $error("Five high selects did not reach reset.");

	// A low select in idle keeps the controller idle.
	a_idle_holds: assert property (@(posedge tck) disable iff (tckRst)
		(state_ff == jtap_pkg::ST_IDLE) && !tms |=> (state_ff == jtap_pkg::ST_IDLE))
		else $error("Idle left on a low select.");

endmodule

`default_nettype wire

/* jtap_test_access_port.sv */
// Test access port of the memory: controller, instruction decode, bypass, identification
// and boundary scan paths, plus the crossing of its results to the memory clock.
// Assumes the pin ring is sampled asynchronously and the memory side runs on mclk.
//
// What this block does
// - Mode select at rising edge chooses each transition.
// - Code 000 captures the ring, external test.
// - Code 001 selects identification word, memory undisturbed.
// - Code 010 captures, selects ring, floats outputs.
// - Code 100 captures and selects ring, harmless.
// - Code 111 selects one-cell bypass path.
// - Identification bits 31:29 version, 28:12 part.
// - Identification bits 11:1 hold maker code.
// - Identification bit 0 always one.
// - Input sampled rising edge, output changes falling.
// - Instruction capture loads 01 into low bits.
// - Internal cell 47 enables outputs in external test.
// - Reset and power-up load identification instruction.
`timescale 1ns/1ns
`default_nettype none

module jtap_test_access_port #(
	parameter logic [2:0]  ID_VERSION = 3'h1,     // Arbitrary value.
	parameter logic [16:0] ID_PART    = 17'h0a5a5, // Arbitrary value.
	parameter logic [10:0] ID_MAKER   = 11'h2c3    // Arbitrary value.
) (
	input  wire logic                           mclk,
	input  wire logic                           rst,
	input  wire logic                           tck,
	input  wire logic                           tms,
	input  wire logic                           tdi,
	output logic                                tdo,
	output logic                                tdoEn,
	input  wire logic [jtap_pkg::BSR_LEN-1:0]   pinRing,
	output logic                                memDriveEn,
	output logic                                extestMode,
	output logic      [jtap_pkg::BSR_LEN-1:0]   bsrDrive
);

	// Identification word assembled from its fields; the lowest bit is fixed high.
	localparam logic [jtap_pkg::ID_LEN-1:0] ID_WORD = {ID_VERSION, ID_PART, ID_MAKER, 1'h1};

	// Chooses the data path for an instruction; reserved codes fall back to bypass.
	function automatic jtap_pkg::jtap_path_t drPath(input logic [2:0] ins);
		case (ins)
			jtap_pkg::INS_EXTEST,
			jtap_pkg::INS_SAMPLEZ,
			jtap_pkg::INS_SAMPLE:  drPath = jtap_pkg::PATH_BSR;
			jtap_pkg::INS_IDCODE:  drPath = jtap_pkg::PATH_ID;
			default:               drPath = jtap_pkg::PATH_BYP;
		endcase
	endfunction

	jtap_step_if step (); // Decoded controller steps.

	logic                           tckRst;      // Power-up reset brought onto the test clock.
	logic [jtap_pkg::BSR_LEN-1:0]   pinQ;        // Pin ring after two test-clock flops.
	logic [jtap_pkg::IR_LEN-1:0]    irShift_ff;  // Instruction shift stage.
	logic [jtap_pkg::IR_LEN-1:0]    instr_ff;    // Active instruction.
	logic                           byp_ff;      // Bypass cell.
	logic [jtap_pkg::ID_LEN-1:0]    id_ff;       // Identification shift stage.
	logic [jtap_pkg::BSR_LEN-1:0]   bsr_ff;      // Boundary shift stage.
	logic [jtap_pkg::BSR_LEN-1:0]   bsrUpd_ff;   // Boundary update latches.
	logic [jtap_pkg::BSR_LEN-1:0]   capVec;      // Value captured into the boundary stage.
	logic                           updTog_ff;   // Flips each time the update latches change.
	logic                           driveReq_ff; // Memory outputs may drive, test-clock side.
	logic                           nxt_driveReq;
	logic [jtap_pkg::IR_LEN-1:0]    nxt_instr;   // Instruction that the next rising edge leaves in place.
	logic                           nxt_oeCell;  // Enable cell latch that the next rising edge leaves in place.
	logic                           extReq_ff;   // External test active, test-clock side.
	logic                           drOut;       // Low end of the selected data path.
	logic                           tdo_ff;      // Serial output, falling-edge register.
	logic                           tdoEn_ff;    // Serial output enable, falling-edge register.
	logic [2:0]                     mQ;          // Test-clock levels seen on mclk.
	logic                           togSeen_ff;  // Last toggle level seen on mclk.
	logic                           memDrive_ff; // Output enable toward the memory.
	logic                           extMode_ff;  // External test flag toward the memory.
	logic [jtap_pkg::BSR_LEN-1:0]   bsrDrive_ff; // Update latches copied onto mclk.
	jtap_pkg::jtap_path_t           path;        // Data path of the active instruction.

	// The power-up reset reaches the test clock through two flops; the controller and all test-clock
	// registers except the unreset synchroniser flops reset from it, so no flop sees rst directly on the wrong clock.
	jtap_sync #(.W(1)) u_rstSync (
		.clk (tck),
		.d   (rst),
		.q   (tckRst)
	);

	// The pins change with the memory clock, so they are sampled through two flops first.
	// Capture is still only as good as the pins are stable around the capture edge.
	jtap_sync #(.W(jtap_pkg::BSR_LEN)) u_pinSync (
		.clk (tck),
		.d   (pinRing),
		.q   (pinQ)
	);

	// Controller stepped by the mode select.
	jtap_fsm u_fsm (
		.tck    (tck),
		.tckRst (tckRst),
		.tms    (tms),
		.step   (step)
	);

	assign path = drPath(instr_ff);

	// Instruction shift stage: capture the fixed low pattern, then shift toward the output.
	always_ff @(posedge tck) begin
		if (tckRst) begin
			irShift_ff <= jtap_pkg::INS_IDCODE;
		end else if (step.captureIr) begin
			irShift_ff <= {1'h0, jtap_pkg::IR_CAPTURE_LOW};
		end else if (step.shiftIr) begin
			irShift_ff <= {tdi, irShift_ff[jtap_pkg::IR_LEN-1:1]};
		end
	end

	// Active instruction: identification after reset, new code only at the update step.
	always_ff @(posedge tck) begin
		if (tckRst || step.tlr) begin
			instr_ff <= jtap_pkg::INS_IDCODE;
		end else if (step.updateIr) begin
			instr_ff <= irShift_ff;
		end
	end

	// Bypass cell: cleared on capture, one cell of delay while shifting.
	always_ff @(posedge tck) begin
		if (tckRst) begin
			byp_ff <= jtap_pkg::BYP_CAPTURE;
		end else if (step.captureDr && path == jtap_pkg::PATH_BYP) begin
			byp_ff <= jtap_pkg::BYP_CAPTURE;
		end else if (step.shiftDr && path == jtap_pkg::PATH_BYP) begin
			byp_ff <= tdi;
		end
	end

	// Identification stage: loads the fixed word on capture and shifts it out LSB first.
	always_ff @(posedge tck) begin
		if (tckRst) begin
			id_ff <= ID_WORD;
		end else if (step.captureDr && path == jtap_pkg::PATH_ID) begin
			id_ff <= ID_WORD;
		end else if (step.shiftDr && path == jtap_pkg::PATH_ID) begin
			id_ff <= {tdi, id_ff[jtap_pkg::ID_LEN-1:1]};
		end
	end

	// The internal cell has no pin, so it captures its own latched value instead.
	always_comb begin
		capVec = pinQ;
		capVec[jtap_pkg::OE_CELL] = bsrUpd_ff[jtap_pkg::OE_CELL];
	end

	// Boundary stage: pin snapshot on capture, serial shift with the MSB at the input end.
	always_ff @(posedge tck) begin
		if (tckRst) begin
			bsr_ff <= jtap_pkg::BSR_UPD_RESET;
		end else if (step.captureDr && path == jtap_pkg::PATH_BSR) begin
			bsr_ff <= capVec;
		end else if (step.shiftDr && path == jtap_pkg::PATH_BSR) begin
			bsr_ff <= {tdi, bsr_ff[jtap_pkg::BSR_LEN-1:1]};
		end
	end

	// Update latches: preset with the enable cell high, loaded at the data update step.
	// The toggle announces each change so the memory side copies a settled word.
	always_ff @(posedge tck) begin
		if (tckRst || step.tlr) begin
			bsrUpd_ff <= jtap_pkg::BSR_UPD_RESET;
		end else if (step.updateDr && path == jtap_pkg::PATH_BSR) begin
			bsrUpd_ff <= bsr_ff;
		end
	end

	always_ff @(posedge tck) begin
		if (tckRst) begin
			updTog_ff <= 1'h0;
		end else if (step.updateDr && path == jtap_pkg::PATH_BSR) begin
			updTog_ff <= ~updTog_ff;
		end else if (step.tlr && bsrUpd_ff != jtap_pkg::BSR_UPD_RESET) begin
			// The preset changes the latches as well, so the memory side must copy it too.
			updTog_ff <= ~updTog_ff;
		end
	end

	// Output enable toward the memory: floated by the high-impedance sample, and in
	// external test by a low enable cell; every other instruction leaves the memory alone.
	// The levels follow the values that the instruction and the latches are about to take,
	// so they settle at the update edge itself: the test clock may stop right after an
	// update, and the memory side must not be left one step behind.
	always_comb begin
		nxt_instr  = instr_ff;
		nxt_oeCell = bsrUpd_ff[jtap_pkg::OE_CELL];
		if (step.tlr) begin
			nxt_instr  = jtap_pkg::INS_IDCODE;
			nxt_oeCell = jtap_pkg::BSR_UPD_RESET[jtap_pkg::OE_CELL];
		end else begin
			if (step.updateIr) begin
				nxt_instr = irShift_ff;
			end
			if (step.updateDr && path == jtap_pkg::PATH_BSR) begin
				nxt_oeCell = bsr_ff[jtap_pkg::OE_CELL];
			end
		end
		case (nxt_instr)
			jtap_pkg::INS_SAMPLEZ: nxt_driveReq = 1'h0;
			jtap_pkg::INS_EXTEST:  nxt_driveReq = nxt_oeCell;
			default:               nxt_driveReq = 1'h1;
		endcase
	end

	always_ff @(posedge tck) begin
		if (tckRst) begin
			driveReq_ff <= 1'h1;
			extReq_ff   <= 1'h0;
		end else begin
			driveReq_ff <= nxt_driveReq;
			extReq_ff   <= (nxt_instr == jtap_pkg::INS_EXTEST);
		end
	end

	// Low end of the selected data path.
	always_comb begin
		case (path)
			jtap_pkg::PATH_ID:  drOut = id_ff[0];
			jtap_pkg::PATH_BSR: drOut = bsr_ff[0];
			default:            drOut = byp_ff;
		endcase
	end

	// Serial output changes on the falling edge, half a period after the shift,
	// so the next device sees stable data at its own rising edge.
	always_ff @(negedge tck) begin
		if (tckRst) begin
			tdo_ff   <= 1'h0;
			tdoEn_ff <= 1'h0;
		end else begin
			tdo_ff   <= step.shiftIr ? irShift_ff[0] : drOut;
			tdoEn_ff <= step.shiftIr | step.shiftDr;
		end
	end

	assign tdo   = tdo_ff;
	assign tdoEn = tdoEn_ff;

	// Levels and the update toggle cross to the memory clock.
	jtap_sync #(.W(3)) u_memSync (
		.clk (mclk),
		.d   ({updTog_ff, driveReq_ff, extReq_ff}),
		.q   (mQ)
	);

	// Memory side: copy the update word once its toggle has settled on mclk.
	// The word stays put for at least three test clocks, longer than this crossing takes.
	always_ff @(posedge mclk) begin
		if (rst) begin
			togSeen_ff  <= 1'h0;
			memDrive_ff <= 1'h1;
			extMode_ff  <= 1'h0;
			bsrDrive_ff <= jtap_pkg::BSR_UPD_RESET;
		end else begin
			togSeen_ff  <= mQ[2];
			memDrive_ff <= mQ[1];
			extMode_ff  <= mQ[0];
			if (mQ[2] != togSeen_ff) begin
				bsrDrive_ff <= bsrUpd_ff;
			end
		end
	end

	assign memDriveEn = memDrive_ff;
	assign extestMode = extMode_ff;
	assign bsrDrive   = bsrDrive_ff;

	// Checks on the test clock.
	a_ir_capture_low: assert property (@(posedge tck) disable iff (tckRst)
		step.captureIr |=> (irShift_ff[1:0] == jtap_pkg::IR_CAPTURE_LOW))
		else $error("Instruction capture pattern wrong.");

	a_reset_loads_id: assert property (@(posedge tck) disable iff (tckRst)
		step.tlr |=> (instr_ff == jtap_pkg::INS_IDCODE))
		else $error("Reset state did not load identification.");

	a_id_word_loaded: assert property (@(posedge tck) disable iff (tckRst)
		step.captureDr && instr_ff == jtap_pkg::INS_IDCODE |=> (id_ff == ID_WORD) && id_ff[0])
		else $error("Identification word not captured.");

	a_bypass_one_cell: assert property (@(posedge tck) disable iff (tckRst)
		step.shiftDr && instr_ff == jtap_pkg::INS_BYPASS |=> (byp_ff == $past(tdi)))
		else $error("Bypass did not pass one cell.");

	a_samplez_floats: assert property (@(posedge tck) disable iff (tckRst)
		(instr_ff == jtap_pkg::INS_SAMPLEZ) [*2] |-> !driveReq_ff)
		else $error("Outputs not floated under high-impedance sample.");

	a_extest_cell_oe: assert property (@(posedge tck) disable iff (tckRst)
		$stable(instr_ff) && instr_ff == jtap_pkg::INS_EXTEST && $stable(bsrUpd_ff)
		|-> (driveReq_ff == bsrUpd_ff[jtap_pkg::OE_CELL]))
		else $error("Enable cell does not steer outputs.");

	a_extest_capture: assert property (@(posedge tck) disable iff (tckRst)
		step.captureDr && instr_ff == jtap_pkg::INS_EXTEST |=> (bsr_ff[0] == $past(pinQ[0])))
		else $error("External test did not capture pins.");

	// Shift one bit in, then update: the latch must take the shifted stage.
	sequence bsrShiftThenUpdate;
		step.shiftDr && instr_ff == jtap_pkg::INS_SAMPLE ##[1:4] step.updateDr;
	endsequence

	a_preload_update: assert property (@(posedge tck) disable iff (tckRst)
		bsrShiftThenUpdate |=> (bsrUpd_ff == $past(bsr_ff)) && driveReq_ff)
		else $error("Preload update or drive enable wrong.");

	a_tdo_enable_shift: assert property (@(posedge tck) disable iff (tckRst)
		step.shiftDr ##1 step.shiftDr |-> tdoEn_ff)
		else $error("Serial output not enabled while shifting.");

endmodule

`default_nettype wire

/* jtap_ctl_model.sv */
// Behavioural board-side test controller that makes the test clock and walks the port.
// Assumes the device samples on the rising test clock and drives its output on the falling one.
`timescale 1ns/1ns
`default_nettype none

module jtap_ctl_model (
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	input  wire logic tdo,
	input  wire logic tdoEn
);
	localparam int HALF = 24; // Half of the 48 ns test clock period.

	// The test clock stands low between frames; it never runs free.
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end

	// One test clock period; mode and data settle while the clock is low.
	task automatic tick(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#HALF;
		o = tdoEn ? tdo : 1'bx; // An undriven output never counts as data.
		tck = 1'b1;
		#(HALF / 2);
		tdi = ~d; // After the hold time the data line no longer shows the old bit.
		#(HALF / 2);
		tck = 1'b0;
	endtask

	// A run of periods at one mode level.
	task automatic walk(input int n, input logic m);
		logic o;
		for (int i = 0; i < n; i++) begin
			tick(m, 1'b0, o);
		end
	endtask

	// Five rises with mode high reach the reset state, then one step to idle.
	task automatic reset_tap();
		walk(5, 1'b1);
		walk(1, 1'b0);
	endtask

	// Full scan from idle back to idle, shifting LSB first.
	task automatic scan(input logic isIr, input int len, input logic [127:0] din, output logic [127:0] dout);
		logic o;
		dout = '0;
		tick(1'b1, 1'b0, o);
		if (isIr) begin
			tick(1'b1, 1'b0, o);
		end
		tick(1'b0, 1'b0, o);
		tick(1'b0, 1'b0, o);
		for (int i = 0; i < len; i++) begin
			tick(i == len - 1, din[i], o);
			dout[i] = o;
		end
		tick(1'b1, 1'b0, o);
		// The rise that enters idle performs the update; the clock then stands still.
		tick(1'b0, 1'b0, o);
	endtask
endmodule

`default_nettype wire

/* tb_top.sv */
// Self-checking bench of the test access port with a board-side controller model.
// Assumes the design package and interface files are compiled first.
`timescale 1ns/1ns
`default_nettype none

module tb_top;
	localparam logic [2:0]   VER     = 3'h5;     // Arbitrary value.
	localparam logic [16:0]  PART    = 17'h1b2c3; // Arbitrary value.
	localparam logic [10:0]  MAKER   = 11'h3a1;  // Arbitrary value.
	localparam logic [127:0] ID_WORD = {96'h0, VER, PART, MAKER, 1'h1};

	logic                            mclk;        // Memory clock.
	logic                            rst;         // Power-up reset.
	logic                            tck;         // Test clock from the model.
	logic                            tms;         // Mode select from the model.
	logic                            tdi;         // Serial data from the model.
	logic                            tdo;         // Serial data from the port.
	logic                            tdoEn;       // Output driver enable.
	logic                            memDriveEn;  // Memory output enable.
	logic                            extestMode;  // External test active.
	logic [jtap_pkg::BSR_LEN-1:0]    pinRing;     // Pin states fed to the ring.
	logic [jtap_pkg::BSR_LEN-1:0]    bsrDrive;    // Update latches seen on the memory side.
	logic [jtap_pkg::BSR_LEN-1:0]    latch;       // Expected update latch contents.
	logic [127:0]                    expQ[$];     // Expected results, oldest first.
	logic [127:0]                    got;         // Result handed to the watcher.
	logic [127:0]                    rd;          // Data returned by a scan.
	logic [127:0]                    d;           // Random scan data.
	logic [2:0]                      resv[4];     // Codes loaded before the bypass runs.
	logic [31:0]                     seed;        // Generator state.
	event                            gotEv;       // A result is ready.
	int                              errors;      // Mismatch count.
	int                              comparisons; // Comparison count.

	jtap_test_access_port #(.ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER)) u_dut (
		.mclk(mclk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoEn(tdoEn),
		.pinRing(pinRing), .memDriveEn(memDriveEn), .extestMode(extestMode), .bsrDrive(bsrDrive));
	jtap_ctl_model u_ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoEn(tdoEn));

	// Memory clock at 25 MHz.
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// Xorshift step; a fixed start value keeps every run the same.
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	// Four generator steps give one wide random word.
	task automatic rnd(output logic [127:0] r);
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			r = {r[95:0], seed};
		end
	endtask

	// Note an expectation and hand the matching result to the watcher.
	task automatic note(input logic [127:0] e, input logic [127:0] g);
		expQ.push_back(e);
		got = g;
		->gotEv;
		#1;
	endtask

	// Watcher: compares each result with the oldest expectation.
	initial begin : watch
		logic [127:0] e;
		forever begin
			@(gotEv);
			e = expQ.pop_front();
			comparisons++;
			if (got !== e) begin
				errors++;
				$display("mismatch at %0t: expected %h got %h", $time, e, got);
			end
		end
	end

	// Bounded wait for the memory-side levels, then one comparison.
	task automatic mem_side(input logic en, input logic ext, input logic [jtap_pkg::BSR_LEN-1:0] drv);
		logic [127:0] e;
		e = {19'h0, en, ext, drv};
		for (int i = 0; i < 16 && {19'h0, memDriveEn, extestMode, bsrDrive} !== e; i++) begin
			@(posedge mclk);
			#1;
		end
		note(e, {19'h0, memDriveEn, extestMode, bsrDrive});
	endtask

	// Instruction scan; the capture pattern leaves first.
	task automatic ir(input logic [2:0] code);
		u_ctl.scan(1'b1, 3, {125'h0, code}, rd);
		note(128'h1, rd);
	endtask

	// Ring scan with fresh pins; the internal cell reads back its own latch.
	task automatic bsr(input logic [jtap_pkg::BSR_LEN-1:0] din);
		logic [127:0] e;
		rnd(e);
		@(posedge mclk);
		#2;
		pinRing = e[106:0];
		e = {21'h0, pinRing};
		e[jtap_pkg::OE_CELL] = latch[jtap_pkg::OE_CELL];
		u_ctl.scan(1'b0, jtap_pkg::BSR_LEN, {21'h0, din}, rd);
		note(e, rd);
		latch = din;
	endtask

	// Identification scan straight after a reset of the controller.
	task automatic id_scan();
		u_ctl.scan(1'b0, 32, 128'h0, rd);
		note(ID_WORD, rd);
	endtask

	task automatic tally_and_finish();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Main sequence; reset is held until the test clock has run through it.
	initial begin
		errors = 0;
		comparisons = 0;
		seed = 32'h5e14;
		rst = 1'b1;
		pinRing = '0;
		latch = jtap_pkg::BSR_UPD_RESET;
		// Only implemented codes are loaded; the reserved ones stay unused.
		resv = '{jtap_pkg::INS_BYPASS, jtap_pkg::INS_BYPASS, jtap_pkg::INS_BYPASS, jtap_pkg::INS_BYPASS};
		u_ctl.reset_tap();
		repeat (3) @(posedge mclk);
		#2;
		rst = 1'b0;
		u_ctl.walk(3, 1'b0);
		note(128'h0, {127'h0, tdoEn});
		mem_side(1'b1, 1'b0, latch);
		id_scan();
		ir(jtap_pkg::INS_SAMPLEZ);
		bsr(latch);
		mem_side(1'b0, 1'b0, latch);
		u_ctl.reset_tap();
		latch = jtap_pkg::BSR_UPD_RESET;
		mem_side(1'b1, 1'b0, latch);
		id_scan();
		foreach (resv[i]) begin
			ir(resv[i]);
			rnd(d);
			u_ctl.scan(1'b0, 8, {120'h0, d[7:0]}, rd);
			note({120'h0, d[6:0], jtap_pkg::BYP_CAPTURE}, rd);
			mem_side(1'b1, 1'b0, latch);
		end
		ir(jtap_pkg::INS_SAMPLE);
		rnd(d);
		d[jtap_pkg::OE_CELL] = 1'b1;
		bsr(d[106:0]);
		mem_side(1'b1, 1'b0, latch);
		ir(jtap_pkg::INS_EXTEST);
		mem_side(1'b1, 1'b1, latch);
		for (int k = 0; k < 2; k++) begin
			rnd(d);
			d[jtap_pkg::OE_CELL] = k[0];
			bsr(d[106:0]);
			mem_side(k[0], 1'b1, latch);
		end
		tally_and_finish();
	end
endmodule

`default_nettype wire
